// [adc_irq_pkg.sv]
// package: register map, event layout and carriers of the adc interrupt block
package adc_irq_pkg;

    // sizes of the block
    localparam int NUM_CH   = 8;   // converter channels
    localparam int CH_W     = 3;   // bits of a channel number
    localparam int NUM_EVT  = 22;  // interrupt sources
    localparam int DATA_W   = 32;  // bus data width
    localparam int ADDR_W   = 12;  // decoded address bits
    localparam int PPI_W    = 16;  // interconnect channels
    localparam int PUBLISH_CHANNEL_INDEX_W  = 4;   // interconnect channel index width
    localparam int SAMPLE_W = 16;  // result and limit width
    localparam int PAD_W    = DATA_W - NUM_EVT;

    // byte offsets of the registers
    localparam logic [ADDR_W-1:0] OFS_PUB_LOW  = 12'h19C;  // first low-limit publish register
    localparam logic [ADDR_W-1:0] PUB_STRIDE   = 12'h008;  // spacing between channels
    localparam logic [ADDR_W-1:0] OFS_INTERRUPT_ENABLE    = 12'h300;
    localparam logic [ADDR_W-1:0] OFS_INTERRUPT_ENABLE_SET = 12'h304;
    localparam logic [ADDR_W-1:0] OFS_INTERRUPT_ENABLE_CLEAR = 12'h308;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 12'h310;  // sticky event flags

    // event bit positions, limit pairs follow from BIT_LIMIT_BASE
    localparam int BIT_STARTED    = 0;
    localparam int BIT_END        = 1;
    localparam int BIT_DONE       = 2;
    localparam int BIT_RESULT     = 3;
    localparam int BIT_CALIB      = 4;
    localparam int BIT_STOPPED    = 5;
    localparam int BIT_LIMIT_BASE = 6;  // high at base+2n, low at base+2n+1

    // publish register fields
    localparam int PUB_IDX_LSB = 0;
    localparam int PUB_EN_BIT  = 31;

    // values after reset
    localparam logic [NUM_EVT-1:0] INTERRUPT_ENABLE_RESET  = 22'h000000;
    localparam logic [NUM_EVT-1:0] STATUS_RESET = 22'h000000;
    localparam logic [DATA_W-1:0]  RDATA_RESET  = 32'h00000000;

    // bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

    typedef logic [NUM_EVT-1:0]                evt_vec_t;     // one bit per event
    typedef logic [NUM_CH-1:0][SAMPLE_W-1:0]   limit_bank_t;  // per-channel limit values

    // one low-limit publish configuration
    typedef struct packed {
        logic               en;     // publishing on
        logic [PUBLISH_CHANNEL_INDEX_W-1:0] publish_channel_index;  // interconnect channel
    } pub_cfg_s;
    typedef pub_cfg_s [NUM_CH-1:0] pub_cfg_bank_t;
    localparam pub_cfg_s PUB_CFG_RESET = '{en: 1'h0, publish_channel_index: 4'h0};

    // one-cycle pulses from the conversion engine
    typedef struct packed {
        logic started;
        logic buffer_full;     // result buffer in ram filled
        logic conv_done;
        logic result_ready;
        logic calib_complete;
        logic stopped_evt;
    } global_evt_s;

    // last result of a channel, valid for one cycle
    typedef struct packed {
        logic                valid;
        logic [CH_W-1:0]     chan;
        logic [SAMPLE_W-1:0] value;  // two's complement
    } result_s;

    // bus slave phases
    typedef enum logic [1:0] {
        BUS_IDLE    = 2'b00,
        BUS_WRITE   = 2'b01,
        BUS_RD_WAIT = 2'b10,
        BUS_RD_DATA = 2'b11
    } bus_state_e;

endpackage

// [limit_compare.sv]
// module: per-channel high and low limit comparison of the last result
`timescale 1ns/1ns
`default_nettype none
module limit_compare (
    input  wire logic                     hclk,       // bus clock
    input  wire logic                     hresetn,    // async reset, low
    input  wire logic                     clk_en,     // freezes state when low
    input  wire adc_irq_pkg::result_s     result,     // last result
    input  wire adc_irq_pkg::limit_bank_t high_limit, // high limits
    input  wire adc_irq_pkg::limit_bank_t low_limit,  // low limits
    output logic [adc_irq_pkg::NUM_CH-1:0] high_evt,  // pulse, at or above high
    output logic [adc_irq_pkg::NUM_CH-1:0] low_evt    // pulse, at or below low
);
    import adc_irq_pkg::*;

    // signed compare, one cycle pulse for the channel that produced the result
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            high_evt <= '0;
            low_evt  <= '0;
        end else if (clk_en) begin
            high_evt <= '0;
            low_evt  <= '0;
            if (result.valid) begin
                high_evt[result.chan] <= $signed(result.value) >= $signed(high_limit[result.chan]);
                low_evt[result.chan]  <= $signed(result.value) <= $signed(low_limit[result.chan]);
            end
        end
    end

    property p_high_limit;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && result.valid && ($signed(result.value) >= $signed(high_limit[result.chan])))
            |=> high_evt[$past(result.chan)];
    endproperty
    a_high_limit: assert property (p_high_limit) else $error("high limit event missing");

endmodule // limit_compare
`default_nettype wire

// [publish_router.sv]
// module: routes low-limit events onto the interconnect channels
`timescale 1ns/1ns
`default_nettype none
module publish_router (
    input  wire logic                       hclk,     // bus clock
    input  wire logic                       hresetn,  // async reset, low
    input  wire logic                       clk_en,   // freezes state when low
    input  wire logic [adc_irq_pkg::NUM_CH-1:0] low_evt, // low-limit pulses
    input  wire adc_irq_pkg::pub_cfg_bank_t cfg,      // publish configuration
    output logic [adc_irq_pkg::PPI_W-1:0]   pub_pulse // one pulse per channel hit
);
    import adc_irq_pkg::*;

    logic [PPI_W-1:0] pub_next;  // channels hit this cycle

    // several sources may share one channel; their pulses merge
    always_comb begin
        pub_next = '0;
        for (int ch = 0; ch < NUM_CH; ch++) begin
            if (low_evt[ch] && cfg[ch].en) begin
                pub_next[cfg[ch].publish_channel_index] = 1'b1;
            end
        end
    end

    // registered so the output leaves a flip-flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pub_pulse <= '0;
        end else if (clk_en) begin
            pub_pulse <= pub_next;
        end
    end

    property p_publish_route;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && low_evt[0] && cfg[0].en) |=> pub_pulse[$past(cfg[0].publish_channel_index)];
    endproperty
    a_publish_route: assert property (p_publish_route) else $error("publish pulse missing");

endmodule // publish_router
`default_nettype wire

// [adc_interrupt_enable_publish.sv]
// module: adc interrupt enable bank, event flags and low-limit publish registers
//
// Notes on behaviour
// - one low-limit publish register per channel
// - publish register carries interconnect channel index
// - enable bits: six globals, then limit pairs
// - enable register write stores bits, resets zero
// - set register ones set enable bits
// - set and clear registers read enable state
// - clear register ones clear enable bits
// - end flag set when buffer filled
// - high event when result at or above
`timescale 1ns/1ns
`default_nettype none
module adc_interrupt_enable_publish (
    input  wire logic                       hclk,          // bus clock, 20 MHz
    input  wire logic                       hresetn,       // async reset, low
    input  wire logic                       clk_en,        // freezes all state when low
    input  wire logic                       hsel,          // slave select
    input  wire logic [31:0]                haddr,         // byte address
    input  wire logic [1:0]                 htrans,        // transfer type
    input  wire logic                       hwrite,        // write when high
    input  wire logic [2:0]                 hsize,         // word only
    input  wire logic [31:0]                hwdata,        // write data
    input  wire logic                       hready,        // bus ready
    output logic [31:0]                     hrdata,        // read data
    output logic                            hreadyout,     // slave ready
    output logic                            hresp,         // always okay
    input  wire adc_irq_pkg::global_evt_s   global_evt,    // engine event pulses
    input  wire adc_irq_pkg::result_s       result,        // last result
    input  wire adc_irq_pkg::limit_bank_t   high_limit,    // per-channel high limits
    input  wire adc_irq_pkg::limit_bank_t   low_limit,     // per-channel low limits
    output logic                            irq,           // level interrupt
    output logic [adc_irq_pkg::PPI_W-1:0]   publish_pulse  // interconnect pulses
);
    import adc_irq_pkg::*;

    bus_state_e        state_reg;      // bus phase
    bus_state_e        state_next;
    logic [ADDR_W-1:0] addr_reg;       // address of the data phase
    evt_vec_t          interrupt_enable_reg;      // interrupt enable bank
    evt_vec_t          status_reg;     // sticky event flags
    evt_vec_t          hw_events;      // this cycle's event pulses
    pub_cfg_bank_t     pub_cfg_reg;    // low-limit publish configs
    logic [DATA_W-1:0] hrdata_reg;     // read data flop
    logic              hreadyout_reg;  // ready flop
    logic              hresp_reg;      // response flop
    logic              irq_reg;        // interrupt flop
    logic [NUM_CH-1:0] high_evt;       // limit pulses
    logic [NUM_CH-1:0] low_evt;
    logic [PPI_W-1:0]  pub_pulse;      // routed publish pulses
    logic              accept;         // address phase taken
    logic              wr_now;         // write data phase this cycle
    logic              rd_now;         // read data sampled this cycle
    logic [CH_W:0]     wr_slot;        // hit and index of a publish register
    logic [CH_W:0]     rd_slot;
    logic [DATA_W-1:0] rdata_mux;      // read value

    // decodes a publish register address into {hit, channel}
    function automatic logic [CH_W:0] pub_slot(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] d;
        logic              hit;
        d   = a - OFS_PUB_LOW;
        hit = (a >= OFS_PUB_LOW) && (d[2:0] == 3'h0)
              && (d < PUB_STRIDE * ADDR_W'(NUM_CH));
        return {hit, d[CH_W+2:3]};
    endfunction

    // packs engine and limit pulses into the enable layout
    function automatic evt_vec_t pack_events(input global_evt_s g,
                                             input logic [NUM_CH-1:0] hi,
                                             input logic [NUM_CH-1:0] lo);
        evt_vec_t v;
        v               = '0;
        v[BIT_STARTED]  = g.started;
        v[BIT_END]      = g.buffer_full;
        v[BIT_DONE]     = g.conv_done;
        v[BIT_RESULT]   = g.result_ready;
        v[BIT_CALIB]    = g.calib_complete;
        v[BIT_STOPPED]  = g.stopped_evt;
        for (int ch = 0; ch < NUM_CH; ch++) begin
            v[BIT_LIMIT_BASE + 2*ch]     = hi[ch];
            v[BIT_LIMIT_BASE + 2*ch + 1] = lo[ch];
        end
        return v;
    endfunction

    limit_compare u_limit_compare (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .clk_en     (clk_en),
        .result     (result),
        .high_limit (high_limit),
        .low_limit  (low_limit),
        .high_evt   (high_evt),
        .low_evt    (low_evt)
    );

    publish_router u_publish_router (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .clk_en    (clk_en),
        .low_evt   (low_evt),
        .cfg       (pub_cfg_reg),
        .pub_pulse (pub_pulse)
    );

    assign hw_events = pack_events(global_evt, high_evt, low_evt);
    assign accept    = hsel && (htrans == HTRANS_NONSEQ) && hready;
    assign wr_now    = clk_en && (state_reg == BUS_WRITE);
    assign rd_now    = clk_en && (state_reg == BUS_RD_WAIT);
    assign wr_slot   = pub_slot(addr_reg);
    assign rd_slot   = pub_slot(addr_reg);

    // next bus phase; reads take one wait state so a write just before is seen
    always_comb begin
        case (state_reg)
            BUS_IDLE, BUS_WRITE, BUS_RD_DATA: begin
                if (accept) begin
                    state_next = hwrite ? BUS_WRITE : BUS_RD_WAIT;
                end else begin
                    state_next = BUS_IDLE;
                end
            end
            BUS_RD_WAIT: state_next = BUS_RD_DATA;  // address phases ignored while stalled
            default:     state_next = BUS_IDLE;
        endcase
    end

    // bus phase, captured address and ready
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg     <= BUS_IDLE;
            addr_reg      <= '0;
            hreadyout_reg <= 1'b1;
            hresp_reg     <= HRESP_OKAY;
        end else if (clk_en) begin
            state_reg     <= state_next;
            hreadyout_reg <= (state_next != BUS_RD_WAIT);
            hresp_reg     <= HRESP_OKAY;
            if (accept && (state_reg != BUS_RD_WAIT)) begin
                addr_reg <= haddr[ADDR_W-1:0];
            end
        end
    end

    // enable bank: direct, set and clear views of the same bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            interrupt_enable_reg <= INTERRUPT_ENABLE_RESET;
        end else if (wr_now) begin
            case (addr_reg)
                OFS_INTERRUPT_ENABLE:    interrupt_enable_reg <= hwdata[NUM_EVT-1:0];
                OFS_INTERRUPT_ENABLE_SET: interrupt_enable_reg <= interrupt_enable_reg | hwdata[NUM_EVT-1:0];
                OFS_INTERRUPT_ENABLE_CLEAR: interrupt_enable_reg <= interrupt_enable_reg & ~hwdata[NUM_EVT-1:0];
                default:      interrupt_enable_reg <= interrupt_enable_reg;
            endcase
        end
    end

    // low-limit publish registers, one per channel
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                pub_cfg_reg[ch] <= PUB_CFG_RESET;
            end
        end else if (wr_now && wr_slot[CH_W]) begin
            pub_cfg_reg[wr_slot[CH_W-1:0]].en    <= hwdata[PUB_EN_BIT];
            pub_cfg_reg[wr_slot[CH_W-1:0]].publish_channel_index <= hwdata[PUB_IDX_LSB +: PUBLISH_CHANNEL_INDEX_W];
        end
    end

    // sticky flags; a read clears them but a pulse in the same cycle survives
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_reg <= STATUS_RESET;
        end else if (clk_en) begin
            if (rd_now && (addr_reg == OFS_STATUS)) begin
                status_reg <= hw_events;
            end else begin
                status_reg <= status_reg | hw_events;
            end
        end
    end

    // read value of the captured address
    always_comb begin
        rdata_mux = '0;
        case (addr_reg)
            OFS_INTERRUPT_ENABLE, OFS_INTERRUPT_ENABLE_SET, OFS_INTERRUPT_ENABLE_CLEAR: begin
                rdata_mux = {{PAD_W{1'b0}}, interrupt_enable_reg};
            end
            OFS_STATUS: begin
                rdata_mux = {{PAD_W{1'b0}}, status_reg};
            end
            default: begin
                if (rd_slot[CH_W]) begin
                    rdata_mux[PUB_EN_BIT]                = pub_cfg_reg[rd_slot[CH_W-1:0]].en;
                    rdata_mux[PUB_IDX_LSB +: PUBLISH_CHANNEL_INDEX_W]    = pub_cfg_reg[rd_slot[CH_W-1:0]].publish_channel_index;
                end
            end
        endcase
    end

    // read data is loaded in the wait state and held until the next read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= RDATA_RESET;
        end else if (rd_now) begin
            hrdata_reg <= rdata_mux;
        end
    end

    // interrupt level and publish pulses, both from flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_reg <= 1'b0;
        end else if (clk_en) begin
            irq_reg <= |(status_reg & interrupt_enable_reg);
        end
    end

    assign hrdata        = hrdata_reg;
    assign hreadyout     = hreadyout_reg;
    assign hresp         = hresp_reg;
    assign irq           = irq_reg;
    assign publish_pulse = pub_pulse;

    // a data phase of a write to the given register
    sequence s_wr(logic [ADDR_W-1:0] ofs);
        wr_now && (addr_reg == ofs);
    endsequence

    sequence s_rd_req;
        accept && !hwrite && clk_en && (state_reg != BUS_RD_WAIT);
    endsequence

    property p_interrupt_enable_write;
        @(posedge hclk) disable iff (!hresetn)
        s_wr(OFS_INTERRUPT_ENABLE) |=> (interrupt_enable_reg == $past(hwdata[NUM_EVT-1:0]));
    endproperty
    a_interrupt_enable_write: assert property (p_interrupt_enable_write) else $error("enable write not stored");

    property p_set;
        @(posedge hclk) disable iff (!hresetn)
        s_wr(OFS_INTERRUPT_ENABLE_SET) |=> ((interrupt_enable_reg & $past(hwdata[NUM_EVT-1:0]))
                                == $past(hwdata[NUM_EVT-1:0]));
    endproperty
    a_set: assert property (p_set) else $error("set write did not set bits");

    property p_clear;
        @(posedge hclk) disable iff (!hresetn)
        s_wr(OFS_INTERRUPT_ENABLE_CLEAR) |=> ((interrupt_enable_reg & $past(hwdata[NUM_EVT-1:0])) == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("clear write did not clear bits");

    property p_zero_no_effect;
        @(posedge hclk) disable iff (!hresetn)
        (s_wr(OFS_INTERRUPT_ENABLE_SET) or s_wr(OFS_INTERRUPT_ENABLE_CLEAR))
            |=> ((interrupt_enable_reg & ~$past(hwdata[NUM_EVT-1:0]))
                 == ($past(interrupt_enable_reg) & ~$past(hwdata[NUM_EVT-1:0])));
    endproperty
    a_zero_no_effect: assert property (p_zero_no_effect) else $error("zero bit changed enable");

    property p_limit_pair_independent;
        @(posedge hclk) disable iff (!hresetn)
        (wr_now && (addr_reg == OFS_INTERRUPT_ENABLE_SET)
         && hwdata[BIT_LIMIT_BASE] && !hwdata[BIT_LIMIT_BASE+1])
            |=> interrupt_enable_reg[BIT_LIMIT_BASE] && $stable(interrupt_enable_reg[BIT_LIMIT_BASE+1]);
    endproperty
    a_limit_pair_independent: assert property (p_limit_pair_independent) else $error("limit pair coupled");

    property p_readback;
        @(posedge hclk) disable iff (!hresetn)
        (rd_now && ((addr_reg == OFS_INTERRUPT_ENABLE_SET) || (addr_reg == OFS_INTERRUPT_ENABLE_CLEAR)))
            |=> (hrdata == {{PAD_W{1'b0}}, $past(interrupt_enable_reg)}) && hreadyout;
    endproperty
    a_readback: assert property (p_readback) else $error("enable read back wrong");

    property p_read_wait;
        @(posedge hclk) disable iff (!hresetn)
        s_rd_req |=> !hreadyout ##1 (!clk_en || hreadyout);
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

    property p_end_flag;
        @(posedge hclk) disable iff (!hresetn)
        (clk_en && global_evt.buffer_full) |=> status_reg[BIT_END] ##1 (!clk_en || irq || !interrupt_enable_reg[BIT_END]);
    endproperty
    a_end_flag: assert property (p_end_flag) else $error("end flag not raised");

    property p_irq_level;
        @(posedge hclk) disable iff (!hresetn)
        clk_en |=> (irq == |($past(status_reg) & $past(interrupt_enable_reg)));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

endmodule // adc_interrupt_enable_publish
`default_nettype wire

// [adc_interrupt_enable_publish_tb.sv]
// testbench: self-checking bench for the adc interrupt enable and publish block
`timescale 1ns/1ns
`default_nettype none
module adc_interrupt_enable_publish_tb;
    import adc_irq_pkg::*;

    logic          hclk       = 1'b0;    // bus clock, 50 ns period
    logic          hresetn    = 1'b0;    // async reset, held low at start
    logic          clk_en     = 1'b1;    // clock enable, low freezes the block
    logic          hsel       = 1'b0;    // slave select
    logic [31:0]   haddr      = 32'h0;   // byte address
    logic [1:0]    htrans     = 2'h0;    // idle until a transfer
    logic          hwrite     = 1'b0;    // write when high
    logic [31:0]   hwdata     = 32'h0;   // write data
    logic [31:0]   hrdata;               // read data
    logic          hreadyout;            // slave ready, also the bus ready
    logic          hresp;                // response, checked okay on every read
    global_evt_s   global_evt = 6'h00;   // engine pulses
    result_s       result     = '0;      // last result
    logic          irq;                  // level interrupt
    logic [15:0]   publish_pulse;        // interconnect pulses
    logic [31:0]   rd_data;              // data taken by the last read
    int            miscompares = 0;      // mismatches seen
    int            compares    = 0;      // comparisons made
    // channel 2 high limit is 100, channel 3 low limit is -100, the rest fire only at 16'h7FFF or 16'h8000
    limit_bank_t high_limit = {{5{16'h7FFF}}, 16'h0064, {2{16'h7FFF}}};
    limit_bank_t low_limit  = {{4{16'h8000}}, 16'hFF9C, {3{16'h8000}}};

    // free-running bus clock
    always #25 hclk = ~hclk;

    adc_interrupt_enable_publish dut (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .clk_en        (clk_en),
        .hsel          (hsel),
        .haddr         (haddr),
        .htrans        (htrans),
        .hwrite        (hwrite),
        .hsize         (3'h2),
        .hwdata        (hwdata),
        .hready        (hreadyout),
        .hrdata        (hrdata),
        .hreadyout     (hreadyout),
        .hresp         (hresp),
        .global_evt    (global_evt),
        .result        (result),
        .high_limit    (high_limit),
        .low_limit     (low_limit),
        .irq           (irq),
        .publish_pulse (publish_pulse)
    );

    // prints counts and verdict, then ends the run
    task automatic conclude;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // one comparison; case inequality so an unknown never matches
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    // looks at ready mid-cycle so the following edge samples a settled value
    task automatic wait_rdy;
        int n;
        n = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1 && n < 20) begin
            @(negedge hclk);
            n++;
        end
        if (n >= 20) begin
            $display("unexpected at %0t: bus wait ran out", $time);
            miscompares++;
            conclude();
        end
        rd_data = hrdata;
        @(posedge hclk);
    endtask

    // one single-word transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        wait_rdy();
    endtask

    // read and compare in one go
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd_data, exp);
        chk({31'h0, hresp}, 32'h0);
    endtask

    // one-cycle engine pulse; returns where the interrupt has had time to rise
    task automatic fire_evt(input logic [5:0] e);
        @(posedge hclk);
        global_evt <= e;
        @(posedge hclk);
        global_evt <= 6'h00;
        repeat (2) @(posedge hclk);
        @(negedge hclk);
    endtask

    // one-cycle result; returns in the cycle where a publish pulse stands
    task automatic fire_res(input logic [2:0] ch, input logic [15:0] v);
        @(posedge hclk);
        result <= {1'b1, ch, v};
        @(posedge hclk);
        result <= {1'b0, ch, v};
        @(posedge hclk);
        @(negedge hclk);
    endtask

    // enable views and the first and last publish registers read zero after reset, an unmapped place too
    task automatic t_reset;
        @(negedge hclk);
        chk({31'h0, irq}, 32'h0);
        chk({16'h0, publish_pulse}, 32'h0);
        chk({31'h0, hreadyout}, 32'h1);
        rd(OFS_INTERRUPT_ENABLE, 32'h0);
        rd(OFS_INTERRUPT_ENABLE_SET, 32'h0);
        rd(OFS_INTERRUPT_ENABLE_CLEAR, 32'h0);
        rd(OFS_PUB_LOW, 32'h0);
        rd(OFS_PUB_LOW + 12'h038, 32'h0);
        rd(12'h200, 32'h0);
    endtask

    // direct write, set and clear, with zeros that must change nothing
    task automatic t_enable;
        bus(1'b1, OFS_INTERRUPT_ENABLE, 32'hFFFFFFFF);
        rd(OFS_INTERRUPT_ENABLE, 32'h003FFFFF);
        bus(1'b1, OFS_INTERRUPT_ENABLE, 32'h00000055);
        bus(1'b1, OFS_INTERRUPT_ENABLE_SET, 32'h00000300);
        rd(OFS_INTERRUPT_ENABLE_SET, 32'h00000355);
        bus(1'b1, OFS_INTERRUPT_ENABLE_CLEAR, 32'h00000011);
        rd(OFS_INTERRUPT_ENABLE_CLEAR, 32'h00000344);
        bus(1'b1, OFS_INTERRUPT_ENABLE_SET, 32'h0);
        bus(1'b1, OFS_INTERRUPT_ENABLE_CLEAR, 32'h0);
        rd(OFS_INTERRUPT_ENABLE, 32'h00000344);
        bus(1'b1, OFS_INTERRUPT_ENABLE, 32'h0);
        rd(OFS_INTERRUPT_ENABLE, 32'h0);
        bus(1'b1, OFS_INTERRUPT_ENABLE_SET, 32'h00000040);
        rd(OFS_INTERRUPT_ENABLE_CLEAR, 32'h00000040);
        bus(1'b1, OFS_INTERRUPT_ENABLE_CLEAR, 32'h00000040);
        rd(OFS_INTERRUPT_ENABLE, 32'h0);
    endtask

    // buffer-full event raises the interrupt only while its enable is set
    task automatic t_irq;
        bus(1'b1, OFS_INTERRUPT_ENABLE_SET, 32'h2);
        fire_evt(6'h10);
        chk({31'h0, irq}, 32'h1);
        rd(OFS_STATUS, 32'h2);
        @(negedge hclk);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, OFS_INTERRUPT_ENABLE_CLEAR, 32'h2);
        fire_evt(6'h10);
        @(negedge hclk);
        chk({31'h0, irq}, 32'h0);
        rd(OFS_STATUS, 32'h2);
        rd(OFS_STATUS, 32'h0);
    endtask

    // result equal to the high limit fires only the high bit of channel 2
    task automatic t_limit;
        bus(1'b1, OFS_INTERRUPT_ENABLE, 32'h400);
        fire_res(3'h2, 16'h0064);
        @(negedge hclk);
        chk({31'h0, irq}, 32'h1);
        rd(OFS_STATUS, 32'h400);
        bus(1'b1, OFS_INTERRUPT_ENABLE, 32'h0);
    endtask

    // publish register fields, and a pulse only where publishing is on
    task automatic t_publish;
        bus(1'b1, OFS_PUB_LOW + 12'h018, 32'h80000005);
        rd(OFS_PUB_LOW + 12'h018, 32'h80000005);
        bus(1'b1, OFS_PUB_LOW, 32'h7FFFFFF3);
        rd(OFS_PUB_LOW, 32'h00000003);
        fire_res(3'h3, 16'hFF38);
        chk({16'h0, publish_pulse}, 32'h20);
        fire_res(3'h0, 16'h8000);
        chk({16'h0, publish_pulse}, 32'h0);
        rd(OFS_STATUS, 32'h2080);
    endtask

    // pulses that arrive while the clock enable is low are lost, irq holds
    task automatic t_freeze;
        bus(1'b1, OFS_INTERRUPT_ENABLE, 32'h0000003F);
        @(posedge hclk);
        clk_en <= 1'b0;
        fire_evt(6'h3F);
        chk({31'h0, irq}, 32'h0);
        @(posedge hclk);
        clk_en <= 1'b1;
        rd(OFS_STATUS, 32'h0);
        bus(1'b1, OFS_INTERRUPT_ENABLE, 32'h0);
    endtask

    // reset for 8 cycles, then the scenarios in turn
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_enable();
        t_irq();
        t_limit();
        t_publish();
        t_freeze();
        conclude();
    end
endmodule // adc_interrupt_enable_publish_tb
`default_nettype wire
